// [rtl/clk_sleep_defs.svh]
`ifndef CLK_SLEEP_DEFS_SVH
`define CLK_SLEEP_DEFS_SVH

// Register addresses on the plain register port
`define DIV_REG_ADDR 4'h0
`define PWR_REG_ADDR 4'h1
`define STATUS_REG_ADDR 4'h2

// Divider register layout and values
`define UNLOCK_BIT 7
`define SEL_HI 3
`define SEL_LO 0
`define UNLOCK_WRITE 8'h80
`define UNLOCK_CYCLES 3'h4
`define SEL_MAX 4'h8
`define SEL_RESET_FUSE 4'h3
`define SEL_RESET_PLAIN 4'h0

// Power control register layout
`define ARM_BIT 5
`define MODE_HI 4
`define MODE_LO 3

// Timing: clock period in ns, hold and startup counted in source clock cycles
`define CLK_PERIOD_NS 10
`define WAKE_HOLD_CYCLES 4
`define OSC_STARTUP_CK 6

`endif

// [rtl/clk_sleep_pkg.sv]
package clk_sleep_pkg;

    typedef enum logic [1:0] {
        MODE_IDLE = 2'h0,
        MODE_NOISE = 2'h1,
        MODE_POWER_DOWN = 2'h2,
        MODE_RESERVED = 2'h3
    } sleep_mode_e;

    // Gray order along run -> sleep -> wake; wake -> run flips both bits
    typedef enum logic [1:0] {
        ST_RUN = 2'h0,
        ST_SLEEP = 2'h1,
        ST_WAKE = 2'h3
    } sleep_state_e;

    typedef struct packed {
        logic [7:0] cnt;
        logic [3:0] active;
        logic tick;
    } divider_state_s;

    typedef struct packed {
        logic [3:0] divider_select;
        logic unlock;
        logic [1:0] unlock_age;
        logic sleep_arm;
        sleep_mode_e mode_sel;
        sleep_state_e state;
        sleep_mode_e active_mode;
        logic [7:0] hold_cnt;
        logic [7:0] rdata;
        logic irq_resume;
        logic reset_wake;
        logic conv_start;
    } ctrl_state_s;

endpackage

// [rtl/clock_enable_divider.sv]
`timescale 1ns/10ps
`include "clk_sleep_defs.svh"

module clock_enable_divider
    import clk_sleep_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] reset_select,
    input wire logic [3:0] requested_select,
    output logic tick
);

    divider_state_s st;
    divider_state_s next_st;
    logic [7:0] limit;

    // New setting is taken only at the end of a full old period, so no short pulse appears
    always_comb begin
        next_st = st;
        limit = 8'(16'h1 << st.active) - 8'h1;
        next_st.tick = 1'b0;
        next_st.cnt = st.cnt + 8'h1;
        if (st.cnt == limit) begin
            next_st.cnt = 8'h0;
            next_st.tick = 1'b1;
            next_st.active = requested_select;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st.cnt <= 8'h0;
            st.active <= reset_select;
            st.tick <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;

endmodule

// [rtl/system_clock_divider_and_sleep.sv]
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/10ps
`include "clk_sleep_defs.svh"

module system_clock_divider_and_sleep
    import clk_sleep_pkg::*;
#(
    parameter int OSC_STARTUP_CYCLES = (`OSC_STARTUP_CK * `CLK_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic divide_by_eight_fuse,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic sleep_instr,
    input wire logic converter_enabled,
    input wire logic other_io_irq,
    input wire logic converter_irq,
    input wire logic mem_ready_irq,
    input wire logic ext0_level_irq,
    input wire logic ext0_edge_irq,
    input wire logic pin_change_irq,
    input wire logic watchdog_irq,
    input wire logic ext_reset,
    input wire logic watchdog_reset,
    input wire logic brownout_reset,
    output logic core_clock_en,
    output logic program_memory_clock_en,
    output logic peripheral_clock_en,
    output logic converter_clock_en,
    output logic main_osc_en,
    output logic core_halted,
    output logic irq_resume,
    output logic reset_wake,
    output logic conversion_start
);

    localparam int IDLE_HOLD = `WAKE_HOLD_CYCLES;
    localparam int PD_HOLD = OSC_STARTUP_CYCLES + `WAKE_HOLD_CYCLES;

    ctrl_state_s st;
    ctrl_state_s next_st;
    logic sys_tick;
    logic div_wr;
    logic pwr_wr;
    logic reset_any;
    logic wake_any;
    logic core_on;
    logic periph_on;
    logic conv_on;
    logic osc_on;
    logic [3:0] reset_select;

    assign reset_select = divide_by_eight_fuse ? `SEL_RESET_FUSE : `SEL_RESET_PLAIN;

    // Counter runs on the undivided clock; only the committed select reaches it
    clock_enable_divider u_divider (
        .clk(clk),
        .sys_rst(sys_rst),
        .reset_select(reset_select),
        .requested_select(st.divider_select),
        .tick(sys_tick)
    );

    assign div_wr = reg_wr && (reg_addr == `DIV_REG_ADDR);
    assign pwr_wr = reg_wr && (reg_addr == `PWR_REG_ADDR);
    assign reset_any = ext_reset || watchdog_reset || brownout_reset;

    // Wake sources per mode; the core presents only enabled pending interrupts
    always_comb begin
        case (st.active_mode)
            MODE_IDLE: wake_any = other_io_irq || converter_irq || mem_ready_irq || ext0_level_irq ||
                                  ext0_edge_irq || pin_change_irq || watchdog_irq;
            MODE_NOISE: wake_any = converter_irq || mem_ready_irq || ext0_level_irq ||
                                   pin_change_irq || watchdog_irq;
            MODE_POWER_DOWN: wake_any = ext0_level_irq || pin_change_irq || watchdog_irq;
            default: wake_any = 1'b0;
        endcase
    end

    always_comb begin
        next_st = st;
        next_st.irq_resume = 1'b0;
        next_st.reset_wake = 1'b0;
        next_st.conv_start = 1'b0;
        next_st.rdata = 8'h0;

        // Unlock window
        if (st.unlock) begin
            next_st.unlock_age = st.unlock_age + 2'h1;
            if (st.unlock_age == 2'(`UNLOCK_CYCLES - 3'h1)) begin
                next_st.unlock = 1'b0;
            end
        end
        if (div_wr) begin
            if (reg_wdata == `UNLOCK_WRITE) begin
                if (!st.unlock) begin
                    next_st.unlock = 1'b1;
                    next_st.unlock_age = 2'h0;
                end
                // Already open: window keeps its original end
            end else if (!reg_wdata[`UNLOCK_BIT]) begin
                if (st.unlock && reg_wdata[`SEL_HI:`SEL_LO] <= `SEL_MAX) begin
                    next_st.divider_select = reg_wdata[`SEL_HI:`SEL_LO];
                end
                next_st.unlock = 1'b0;
            end
        end

        if (pwr_wr) begin
            next_st.sleep_arm = reg_wdata[`ARM_BIT];
            next_st.mode_sel = sleep_mode_e'(reg_wdata[`MODE_HI:`MODE_LO]);
        end

        // Read data in the cycle after the strobe only
        if (reg_rd) begin
            if (reg_addr == `DIV_REG_ADDR) begin
                next_st.rdata = {st.unlock, 3'h0, st.divider_select};
            end else if (reg_addr == `PWR_REG_ADDR) begin
                next_st.rdata = {2'h0, st.sleep_arm, st.mode_sel, 3'h0};
            end else if (reg_addr == `STATUS_REG_ADDR) begin
                next_st.rdata = {3'h0, st.active_mode, st.state, osc_on};
            end else begin
                next_st.rdata = 8'h0;
            end
        end

        // Sleep sequencing; no state of the core or memories is touched here
        case (st.state)
            ST_RUN: begin
                if (sleep_instr && st.sleep_arm && st.mode_sel != MODE_RESERVED) begin
                    next_st.state = ST_SLEEP;
                    next_st.active_mode = st.mode_sel;
                    next_st.conv_start = converter_enabled && (st.mode_sel != MODE_POWER_DOWN);
                end
            end
            ST_SLEEP: begin
                if (reset_any) begin
                    next_st.state = ST_RUN;
                    next_st.reset_wake = 1'b1;
                end else if (wake_any) begin
                    next_st.state = ST_WAKE;
                    if (st.active_mode == MODE_POWER_DOWN) begin
                        next_st.hold_cnt = 8'(PD_HOLD - 1);
                    end else begin
                        next_st.hold_cnt = 8'(IDLE_HOLD - 1);
                    end
                end
            end
            ST_WAKE: begin
                if (reset_any) begin
                    next_st.state = ST_RUN;
                    next_st.reset_wake = 1'b1;
                end else if (st.hold_cnt == 8'h0) begin
                    next_st.state = ST_RUN;
                    next_st.irq_resume = 1'b1;
                end else begin
                    next_st.hold_cnt = st.hold_cnt - 8'h1;
                end
            end
            default: begin
                next_st.state = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st.divider_select <= reset_select;
            st.unlock <= 1'b0;
            st.unlock_age <= 2'h0;
            st.sleep_arm <= 1'b0;
            st.mode_sel <= MODE_IDLE;
            st.state <= ST_RUN;
            st.active_mode <= MODE_IDLE;
            st.hold_cnt <= 8'h0;
            st.rdata <= 8'h0;
            st.irq_resume <= 1'b0;
            st.reset_wake <= 1'b0;
            st.conv_start <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // Clock domain gating from the divided tick
    always_comb begin
        core_on = (st.state == ST_RUN);
        periph_on = (st.state != ST_SLEEP) || (st.active_mode == MODE_IDLE);
        conv_on = periph_on || (st.active_mode == MODE_NOISE);
        osc_on = !((st.state == ST_SLEEP) && (st.active_mode == MODE_POWER_DOWN));
    end

    assign core_clock_en = sys_tick && core_on;
    assign program_memory_clock_en = sys_tick && core_on;
    assign peripheral_clock_en = sys_tick && periph_on && osc_on;
    assign converter_clock_en = sys_tick && conv_on && osc_on;
    assign main_osc_en = osc_on;
    assign core_halted = !core_on;
    assign irq_resume = st.irq_resume;
    assign reset_wake = st.reset_wake;
    assign conversion_start = st.conv_start;
    assign reg_rdata = st.rdata;

    sequence s_unlock_write;
        div_wr && reg_wdata == `UNLOCK_WRITE;
    endsequence

    sequence s_wake_entry;
        (st.state == ST_SLEEP) ##1 (st.state == ST_WAKE);
    endsequence

    a_unlock_cause: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(st.unlock) |-> $past(div_wr && reg_wdata == `UNLOCK_WRITE))
        else $error("unlock set without exact unlock write");

    a_unlock_expiry: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(st.unlock) ##0 st.unlock [*4] |=> !st.unlock)
        else $error("unlock window not closed after four cycles");

    a_unlock_rewrite: assert property (@(posedge clk) disable iff (sys_rst)
        (st.unlock && st.unlock_age != 2'h3) ##0 s_unlock_write |=>
        st.unlock && st.unlock_age == 2'($past(st.unlock_age) + 2'h1))
        else $error("rewrite of unlock cleared or restarted window");

    a_reserved_read: assert property (@(posedge clk) disable iff (sys_rst)
        reg_rd && reg_addr == `DIV_REG_ADDR |=> reg_rdata[6:4] == 3'h0 && reg_rdata[3:0] == $past(st.divider_select))
        else $error("divider readback wrong");

    a_select_commit: assert property (@(posedge clk) disable iff (sys_rst)
        div_wr && st.unlock && !reg_wdata[7] && reg_wdata[3:0] <= `SEL_MAX |=>
        st.divider_select == $past(reg_wdata[3:0]) && !st.unlock)
        else $error("unlocked select write not taken");

    a_select_locked: assert property (@(posedge clk) disable iff (sys_rst)
        !st.unlock |=> st.divider_select == $past(st.divider_select))
        else $error("select changed without unlock");

    a_fuse_reset: assert property (@(posedge clk)
        $fell(sys_rst) |-> st.divider_select == (divide_by_eight_fuse ? 4'h3 : 4'h0))
        else $error("divider select wrong after reset");

    a_sleep_arm: assert property (@(posedge clk) disable iff (sys_rst)
        st.state == ST_RUN && sleep_instr |=> (st.state == ST_SLEEP) == ($past(st.sleep_arm) &&
        $past(st.mode_sel) != MODE_RESERVED))
        else $error("sleep entry does not follow arm bit and mode");

    a_powerdown_clocks: assert property (@(posedge clk) disable iff (sys_rst)
        st.state == ST_SLEEP && st.active_mode == MODE_POWER_DOWN |->
        !main_osc_en && !core_clock_en && !peripheral_clock_en && !converter_clock_en)
        else $error("clock running in power-down");

    a_noise_clocks: assert property (@(posedge clk) disable iff (sys_rst)
        st.state == ST_SLEEP && st.active_mode == MODE_NOISE && sys_tick |->
        converter_clock_en && !peripheral_clock_en && !core_clock_en)
        else $error("noise mode gating wrong");

    a_edge_no_wake: assert property (@(posedge clk) disable iff (sys_rst || reset_any)
        st.state == ST_SLEEP && st.active_mode == MODE_POWER_DOWN && !ext0_level_irq &&
        !pin_change_irq && !watchdog_irq |=> st.state == ST_SLEEP)
        else $error("power-down woke on a non-wake source");

    a_idle_hold: assert property (@(posedge clk) disable iff (sys_rst || reset_any)
        s_wake_entry ##0 st.active_mode != MODE_POWER_DOWN |->
        (core_halted && st.state == ST_WAKE)[*4] ##1 (st.irq_resume && !core_halted))
        else $error("idle wake hold not four cycles");

    a_pd_hold: assert property (@(posedge clk) disable iff (sys_rst || reset_any)
        s_wake_entry ##0 st.active_mode == MODE_POWER_DOWN |-> ##PD_HOLD (st.irq_resume && !core_halted))
        else $error("power-down wake hold wrong");

    a_reset_wake: assert property (@(posedge clk) disable iff (sys_rst)
        st.state != ST_RUN && reset_any |=> st.state == ST_RUN && reset_wake && !irq_resume)
        else $error("reset in sleep did not wake to reset vector");

    sequence s_sleep_entry;
        (st.state == ST_RUN) ##1 (st.state == ST_SLEEP);
    endsequence

    a_mode_latch: assert property (@(posedge clk) disable iff (sys_rst)
        s_sleep_entry |-> st.active_mode == $past(st.mode_sel))
        else $error("sleep mode not latched at entry");

    a_conv_start: assert property (@(posedge clk) disable iff (sys_rst)
        st.state == ST_RUN && sleep_instr && st.sleep_arm &&
        (st.mode_sel == MODE_IDLE || st.mode_sel == MODE_NOISE) |=> conversion_start == $past(converter_enabled))
        else $error("conversion start does not follow converter enable");

    a_reserved_noop: assert property (@(posedge clk) disable iff (sys_rst)
        st.state == ST_RUN && sleep_instr && st.mode_sel == MODE_RESERVED |=> st.state == ST_RUN && main_osc_en)
        else $error("reserved mode entered sleep");

    a_run_clocks: assert property (@(posedge clk) disable iff (sys_rst)
        st.state == ST_RUN && sys_tick |->
        core_clock_en && program_memory_clock_en && peripheral_clock_en && converter_clock_en)
        else $error("run domain clock missing");

    a_idle_clocks: assert property (@(posedge clk) disable iff (sys_rst)
        st.state == ST_SLEEP && st.active_mode == MODE_IDLE && sys_tick |->
        peripheral_clock_en && converter_clock_en && main_osc_en && !core_clock_en && !program_memory_clock_en)
        else $error("idle mode gating wrong");

    a_idle_wake: assert property (@(posedge clk) disable iff (sys_rst || reset_any)
        st.state == ST_SLEEP && st.active_mode == MODE_IDLE && (other_io_irq || ext0_edge_irq) |=>
        st.state == ST_WAKE)
        else $error("idle did not wake on interrupt");

    a_noise_wake: assert property (@(posedge clk) disable iff (sys_rst || reset_any)
        st.state == ST_SLEEP && st.active_mode == MODE_NOISE && (converter_irq || mem_ready_irq) |=>
        st.state == ST_WAKE)
        else $error("noise mode did not wake on its source");

    a_noise_quiet: assert property (@(posedge clk) disable iff (sys_rst || reset_any)
        st.state == ST_SLEEP && st.active_mode == MODE_NOISE && !converter_irq && !mem_ready_irq &&
        !ext0_level_irq && !pin_change_irq && !watchdog_irq |=> st.state == ST_SLEEP)
        else $error("noise mode woke on a non-wake source");

    a_resume_pulse: assert property (@(posedge clk) disable iff (sys_rst)
        irq_resume |-> !core_halted ##1 !irq_resume)
        else $error("resume pulse wrong");

endmodule

// [tb/system_clock_divider_and_sleep_test.sv]
`timescale 1ns/10ps
`include "clk_sleep_defs.svh"

module system_clock_divider_and_sleep_test
    import clk_sleep_pkg::*;
;
    localparam int OSC = 2;
    typedef struct packed {
        logic [1:0] mode;
        logic [6:0] quiet;
        logic [6:0] wake;
        logic [2:0] dom;
    } sleep_case_s;
    // Irq order: other_io, converter, mem_ready, ext0_level, ext0_edge, pin_change, watchdog
    sleep_case_s cases [8] = '{'{2'h0, 7'h00, 7'h40, 3'h7}, '{2'h0, 7'h00, 7'h04, 3'h7},
        '{2'h1, 7'h44, 7'h20, 3'h3}, '{2'h1, 7'h44, 7'h10, 3'h3}, '{2'h1, 7'h44, 7'h08, 3'h3},
        '{2'h2, 7'h74, 7'h08, 3'h0}, '{2'h2, 7'h74, 7'h02, 3'h0}, '{2'h2, 7'h74, 7'h01, 3'h0}};
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic divide_by_eight_fuse = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic sleep_instr = 1'b0;
    logic converter_enabled = 1'b1;
    logic [6:0] irq = 7'h00;
    logic [2:0] rst_req = 3'h0;
    logic [7:0] reg_rdata;
    logic core_clock_en, program_memory_clock_en, peripheral_clock_en, converter_clock_en;
    logic main_osc_en, core_halted, irq_resume, reset_wake, conversion_start;
    logic [15:0] n;
    logic [3:0] prev;
    logic [3:0] sels [6] = '{4'h3, 4'h1, 4'h8, 4'h0, 4'h2, 4'h0};
    logic [7:0] refused [3] = '{8'h00, 8'h38, 8'h10};
    int num_errors = 0;
    int cmp_count = 0;
    int cycles = 0;

    system_clock_divider_and_sleep #(.OSC_STARTUP_CYCLES(OSC)) DUT (.clk(clk), .sys_rst(sys_rst),
        .divide_by_eight_fuse(divide_by_eight_fuse), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_instr(sleep_instr),
        .converter_enabled(converter_enabled), .other_io_irq(irq[6]), .converter_irq(irq[5]),
        .mem_ready_irq(irq[4]), .ext0_level_irq(irq[3]), .ext0_edge_irq(irq[2]),
        .pin_change_irq(irq[1]), .watchdog_irq(irq[0]), .ext_reset(rst_req[2]),
        .watchdog_reset(rst_req[1]), .brownout_reset(rst_req[0]), .core_clock_en(core_clock_en),
        .program_memory_clock_en(program_memory_clock_en), .peripheral_clock_en(peripheral_clock_en),
        .converter_clock_en(converter_clock_en), .main_osc_en(main_osc_en), .core_halted(core_halted),
        .irq_resume(irq_resume), .reset_wake(reset_wake), .conversion_start(conversion_start));

    always #5 clk = ~clk;

    task end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Runaway guard, well above the fewer than two thousand cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            num_errors++;
            end_sim();
        end
    end

    task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // One bus cycle; strobes hold until the next call
    task bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
    endtask

    task wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask

    task rd(input logic [3:0] a, input logic [7:0] exp);
        bus(1'b0, 1'b1, a, 8'h00);
        #1;
        check(reg_rdata, exp, "read data");
    endtask

    task idle(input int k);
        repeat (k) bus(1'b0, 1'b0, 4'h0, 8'h00);
    endtask

    task set_sel(input logic [3:0] s);
        wr(`DIV_REG_ADDR, `UNLOCK_WRITE);
        wr(`DIV_REG_ADDR, {4'h0, s});
        idle(1);
    endtask

    // Cycles from one core clock pulse to the next
    task measure(output logic [15:0] k);
        k = 0;
        @(negedge clk);
        while (core_clock_en !== 1'b1 && k < 600) begin
            @(negedge clk);
            k++;
        end
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (core_clock_en !== 1'b1 && k < 600);
    endtask

    task sleep_pulse;
        sleep_instr <= 1'b1;
        idle(1);
        sleep_instr <= 1'b0;
        #1;
    endtask

    task run_sleep(input sleep_case_s c);
        int hold;
        hold = (c.mode == 2'h2) ? OSC + `WAKE_HOLD_CYCLES : `WAKE_HOLD_CYCLES;
        wr(`PWR_REG_ADDR, {2'h0, 1'b1, c.mode, 3'h0});
        rd(`PWR_REG_ADDR, {2'h0, 1'b1, c.mode, 3'h0});
        irq <= c.quiet;
        sleep_pulse();
        check(core_halted, 1'b1, "sleep entered");
        check(conversion_start, c.mode != 2'h2, "conversion start");
        check({core_clock_en, program_memory_clock_en}, 2'h0, "core clocks");
        check({peripheral_clock_en, converter_clock_en, main_osc_en}, c.dom, "domains");
        rd(`STATUS_REG_ADDR, {3'h0, c.mode, 2'h1, c.mode != 2'h2});
        idle(2);
        #1;
        check({core_halted, irq_resume}, 2'h2, "quiet sources");
        irq <= c.wake;
        repeat (hold) @(posedge clk);
        #1;
        check({core_halted, core_clock_en, irq_resume}, 3'h4, "wake hold");
        @(posedge clk);
        #1;
        check({core_halted, irq_resume}, 2'h1, "resume");
        irq <= 7'h00;
    endtask

    initial begin
        idle(16);
        sys_rst <= 1'b0;
        idle(1);
        rd(`DIV_REG_ADDR, {4'h0, `SEL_RESET_PLAIN});
        rd(`PWR_REG_ADDR, 8'h00);
        $display("test reset done");

        wr(`DIV_REG_ADDR, 8'h81);
        rd(`DIV_REG_ADDR, 8'h00);
        wr(`DIV_REG_ADDR, 8'h90);
        rd(`DIV_REG_ADDR, 8'h00);
        set_sel(4'h2);
        wr(`DIV_REG_ADDR, `UNLOCK_WRITE);
        idle(1);
        wr(`DIV_REG_ADDR, `UNLOCK_WRITE);
        rd(`DIV_REG_ADDR, 8'h82);
        rd(`DIV_REG_ADDR, 8'h82);
        rd(`DIV_REG_ADDR, 8'h02);
        wr(`DIV_REG_ADDR, `UNLOCK_WRITE);
        idle(3);
        wr(`DIV_REG_ADDR, 8'h05);
        rd(`DIV_REG_ADDR, 8'h05);
        wr(`DIV_REG_ADDR, `UNLOCK_WRITE);
        idle(4);
        wr(`DIV_REG_ADDR, 8'h01);
        rd(`DIV_REG_ADDR, 8'h05);
        for (int c = 9; c < 16; c++) begin
            wr(`DIV_REG_ADDR, `UNLOCK_WRITE);
            wr(`DIV_REG_ADDR, 8'(c));
            rd(`DIV_REG_ADDR, 8'h05);
        end
        set_sel(4'h0);
        wr(`DIV_REG_ADDR, `UNLOCK_WRITE);
        wr(`DIV_REG_ADDR, 8'h72);
        rd(`DIV_REG_ADDR, 8'h02);
        wr(4'h7, 8'hff);
        rd(4'h7, 8'h00);
        rd(`PWR_REG_ADDR, 8'h00);
        $display("test unlock done");

        prev = 4'h2;
        foreach (sels[i]) begin
            set_sel(sels[i]);
            measure(n);
            check(n >= (16'h1 << ((sels[i] < prev) ? sels[i] : prev)), 1'b1, "switch glitch");
            measure(n);
            check(n, 16'h1 << sels[i], "division factor");
            check({program_memory_clock_en, peripheral_clock_en, converter_clock_en}, 3'h7, "run domains");
            @(posedge clk);
            prev = sels[i];
        end
        $display("test divider done");

        foreach (cases[i]) run_sleep(cases[i]);
        rd(`DIV_REG_ADDR, 8'h00);
        foreach (refused[i]) begin
            wr(`PWR_REG_ADDR, refused[i]);
            sleep_pulse();
            check({core_halted, core_clock_en, main_osc_en}, 3'h3, "sleep refused");
        end
        converter_enabled <= 1'b0;
        for (int r = 0; r < 3; r++) begin
            wr(`PWR_REG_ADDR, 8'h20);
            sleep_pulse();
            check({core_halted, conversion_start}, 2'h2, "sleep without conversion");
            rst_req <= 3'h1 << r;
            @(posedge clk);
            rst_req <= 3'h0;
            #1;
            check({reset_wake, core_halted}, 2'h2, "reset wake");
        end
        $display("test sleep done");

        divide_by_eight_fuse <= 1'b1;
        sys_rst <= 1'b1;
        idle(16);
        sys_rst <= 1'b0;
        idle(1);
        rd(`DIV_REG_ADDR, {4'h0, `SEL_RESET_FUSE});
        idle(1);
        measure(n);
        check(n, 16'h8, "fuse factor");
        $display("test fuse done");
        end_sim();
    end
endmodule
